//--- bst_tap_core.sv
// Boundary-scan access port: pin sampling, instruction and data registers, serial output.
`timescale 1ns/1ps
module bst_tap_core
   import bst_pkg::*;
#(
   parameter int             BSR_LEN = 8,
   parameter logic [3:0]     ID_VERSION = 4'h1,    // Arbitrary value.
   parameter logic [15:0]    ID_PART = 16'h1234,   // Arbitrary value.
   parameter logic [10:0]    ID_MFR = 11'h055      // Arbitrary value.
)
(
   input  wire logic               SYS_CLK_IN,
   input  wire logic               RESET_IN,
   input  wire logic               TEST_CLOCK_INPUT_IN,
   input  wire logic               TEST_MODE_IN,
   input  wire logic               TEST_DATA_IN,
   input  wire logic               TEST_RESET_N_IN,
   input  wire logic [BSR_LEN-1:0] BSC_CAPTURE_IN,
   output logic                    TEST_DATA_OUT,
   output logic                    TEST_DATA_OE_N_OUT,
   output logic [BSR_LEN-1:0]      BSC_UPDATE_OUT,
   output logic                    EXTEST_OUT,
   output logic                    HIGHZ_OUT,
   output logic                    TAP_RESET_OUT
);
   localparam logic [ID_W-1:0] ID_VALUE = (ID_W'(ID_VERSION) << ID_VER_LSB) | (ID_W'(ID_PART) << ID_PART_LSB)
                                        | (ID_W'(ID_MFR) << ID_MFR_LSB) | ID_W'(ID_MARK);

   bst_ctl_if ctl ();

   logic [SYNC_W-1:0]  s1_q;
   logic [SYNC_W-1:0]  s2_q;
   logic [SYNC_W-1:0]  s3_q;
   logic [SYNC_W-1:0]  pins;
   logic               fall;
   logic [IR_W-1:0]    ir_sh_q, ir_sh_d;
   logic [IR_W-1:0]    ir_q, ir_d;
   logic [ID_W-1:0]    id_sh_q, id_sh_d;
   logic [BSR_LEN-1:0] bs_sh_q, bs_sh_d;
   logic [BSR_LEN-1:0] bs_up_q, bs_up_d;
   logic               byp_q, byp_d;
   logic               tdo_q, tdo_d;
   logic               oe_n_q, oe_n_d;
   logic               ext_q, ext_d;
   logic               hiz_q, hiz_d;
   logic               tlr_q, tlr_d;
   logic               sel_bs, sel_id, in_shift;

   // Pins pass three flops; an edge counts when the second and third stages differ.
   assign pins = {TEST_RESET_N_IN, TEST_DATA_IN, TEST_MODE_IN, TEST_CLOCK_INPUT_IN};
   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         s1_q <= 4'h8;                                                // Clock pin parked low, no false edge.
         s2_q <= 4'h8;
         s3_q <= 4'h8;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Rise strobe and settled levels handed to the controller; the fall strobe stays in the core.
   assign ctl.rise = s2_q[PIN_CLK] && !s3_q[PIN_CLK];
   assign fall = !s2_q[PIN_CLK] && s3_q[PIN_CLK];
   assign ctl.tms = s3_q[PIN_MODE];
   assign ctl.trst = !s3_q[PIN_RST];

   bst_tap_fsm u_fsm (
      .clk_in (SYS_CLK_IN),
      .rst_in (RESET_IN),
      .ctl    (ctl)
   );

   // Instruction decode chooses which data register sits in the serial path.
   assign sel_bs = (ir_q == OP_EXTEST) || (ir_q == OP_SAMPLE);
   assign sel_id = (ir_q == OP_IDENT);
   assign in_shift = (ctl.state == ST_SH_DR) || (ctl.state == ST_SH_IR);

   // Next values of all scan registers and of the serial output and its enable.
   always_comb begin
      ir_sh_d = ir_sh_q;
      ir_d = ir_q;
      id_sh_d = id_sh_q;
      bs_sh_d = bs_sh_q;
      bs_up_d = bs_up_q;
      byp_d = byp_q;
      tdo_d = tdo_q;
      oe_n_d = oe_n_q;
      if (ctl.rise) begin
         case (ctl.state)
            ST_CAP_DR: begin
               if (sel_bs) begin
                  bs_sh_d = BSC_CAPTURE_IN;
               end else if (sel_id) begin
                  id_sh_d = ID_VALUE;
               end else begin
                  byp_d = 1'b0;
               end
            end
            ST_SH_DR: begin
               if (sel_bs) begin
                  bs_sh_d = {s3_q[PIN_DATA], bs_sh_q[BSR_LEN-1:1]};
               end else if (sel_id) begin
                  id_sh_d = {s3_q[PIN_DATA], id_sh_q[ID_W-1:1]};
               end else begin
                  byp_d = s3_q[PIN_DATA];
               end
            end
            ST_CAP_IR: ir_sh_d = IR_CAPTURE;
            ST_SH_IR:  ir_sh_d = {s3_q[PIN_DATA], ir_sh_q[IR_W-1:1]};
            default: begin
            end
         endcase
      end
      if (fall) begin
         if (ctl.state == ST_SH_IR) begin
            tdo_d = ir_sh_q[0];
         end else if (sel_bs) begin
            tdo_d = bs_sh_q[0];
         end else if (sel_id) begin
            tdo_d = id_sh_q[0];
         end else begin
            tdo_d = byp_q;
         end
         oe_n_d = !in_shift;
         if (ctl.state == ST_UPD_DR && sel_bs) begin
            bs_up_d = bs_sh_q;
         end
         if (ctl.state == ST_UPD_IR) begin
            ir_d = ir_sh_q;
         end
      end
      if (ctl.state == ST_TLR) begin
         ir_d = IR_RESET;
         oe_n_d = 1'b1;
      end
   end

   // Mode outputs follow the current instruction and are held low in the reset state; the reset output follows the state.
   assign ext_d = (ir_q == OP_EXTEST) && (ctl.state != ST_TLR);
   assign hiz_d = (ir_q == OP_HIGHZ) && (ctl.state != ST_TLR);
   assign tlr_d = (ctl.state == ST_TLR);

   // Registers every scan register and output.
   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         ir_sh_q <= IR_CAPTURE;
         ir_q <= IR_RESET;
         id_sh_q <= '0;
         bs_sh_q <= '0;
         bs_up_q <= '0;
         byp_q <= 1'b0;
         tdo_q <= 1'b0;
         oe_n_q <= 1'b1;
         ext_q <= 1'b0;
         hiz_q <= 1'b0;
         tlr_q <= 1'b1;
      end else begin
         ir_sh_q <= ir_sh_d;
         ir_q <= ir_d;
         id_sh_q <= id_sh_d;
         bs_sh_q <= bs_sh_d;
         bs_up_q <= bs_up_d;
         byp_q <= byp_d;
         tdo_q <= tdo_d;
         oe_n_q <= oe_n_d;
         ext_q <= ext_d;
         hiz_q <= hiz_d;
         tlr_q <= tlr_d;
      end
   end

   assign TEST_DATA_OUT = tdo_q;
   assign TEST_DATA_OE_N_OUT = oe_n_q;
   assign BSC_UPDATE_OUT = bs_up_q;
   assign EXTEST_OUT = ext_q;
   assign HIGHZ_OUT = hiz_q;
   assign TAP_RESET_OUT = tlr_q;

   a_bypass_capture: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (ctl.rise && ctl.state == ST_CAP_DR && !sel_bs && !sel_id) |=> (byp_q == 1'b0))
      else $error("Bypass stage not cleared on capture.");
   a_ir_update_only: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (ir_q != $past(ir_q)) |-> ($past(ctl.state) == ST_UPD_IR || $past(ctl.state) == ST_TLR))
      else $error("Instruction changed outside update or reset.");
   a_pause_holds_dr: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (ctl.state == ST_PA_DR && $past(ctl.state) == ST_PA_DR) |-> ($stable(id_sh_q) && $stable(bs_sh_q) && $stable(byp_q)))
      else $error("Data register moved while paused.");
   a_ident_capture: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (ctl.rise && ctl.state == ST_CAP_DR && sel_id) |=> (id_sh_q[0] == 1'b1 && id_sh_q == ID_VALUE))
      else $error("Identity capture wrong.");
   a_ir_shift_in: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (ctl.rise && ctl.state == ST_SH_IR) |=> (ir_sh_q[IR_W-1] == $past(s3_q[PIN_DATA])))
      else $error("Instruction bit not shifted in.");
   a_out_enable_shift: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (fall && !in_shift) |=> oe_n_q)
      else $error("Serial output driven outside shift.");

   // Capture, shift-out, update and reset behaviour of the scan registers and mode outputs.
   a_capture_chain: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (ctl.rise && ctl.state == ST_CAP_DR && sel_bs) |=> (bs_sh_q == $past(BSC_CAPTURE_IN)))
      else $error("Boundary chain did not capture the parallel inputs.");
   a_tdo_on_fall: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (fall && ctl.state == ST_SH_DR && sel_bs) |=> (tdo_q == $past(bs_sh_q[0])))
      else $error("Serial output did not show the low chain bit.");
   a_bypass_shift: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (ctl.rise && ctl.state == ST_SH_DR && !sel_bs && !sel_id) |=> (byp_q == $past(s3_q[PIN_DATA])))
      else $error("Bypass stage did not take the serial input.");
   a_update_latch: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (fall && ctl.state == ST_UPD_DR && sel_bs) |=> (bs_up_q == $past(bs_sh_q)))
      else $error("Update latches did not take the shifted chain.");
   a_ir_capture: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (ctl.rise && ctl.state == ST_CAP_IR) |=> (ir_sh_q == IR_CAPTURE))
      else $error("Instruction capture pattern not loaded.");
   a_reset_ident: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (ctl.state == ST_TLR) |=> (ir_q == IR_RESET && tlr_q && !ext_q && !hiz_q))
      else $error("Reset state did not restore the identity instruction.");
   a_highz_mode: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (ir_q == OP_HIGHZ && ctl.state != ST_TLR) |=> hiz_q)
      else $error("Float instruction did not raise its mode output.");
   a_shift_enable: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (fall && in_shift) |=> !oe_n_q)
      else $error("Serial output not driven in a shift state.");
endmodule

//--- bst_pkg.sv
// Constants, codes and state type shared by the boundary-scan access port.
package bst_pkg;
   localparam int IR_W = 4;
   localparam int ID_W = 32;
   localparam int SYNC_W = 4;
   localparam int PIN_CLK = 0;
   localparam int PIN_MODE = 1;
   localparam int PIN_DATA = 2;
   localparam int PIN_RST = 3;
   localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;
   localparam logic [IR_W-1:0] OP_SAMPLE = 4'h1;
   localparam logic [IR_W-1:0] OP_IDENT = 4'h2;
   localparam logic [IR_W-1:0] OP_HIGHZ = 4'h3;
   localparam logic [IR_W-1:0] OP_BYPASS = 4'hF;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   localparam logic [IR_W-1:0] IR_RESET = OP_IDENT;
   localparam int ID_VER_LSB = 28;
   localparam int ID_PART_LSB = 12;
   localparam int ID_MFR_LSB = 1;
   localparam logic ID_MARK = 1'h1;
   localparam logic [2:0] ONES_MAX = 3'h7;
   localparam logic [2:0] ONES_RESET = 3'h5;

   typedef enum logic [3:0] {
      ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
   } bst_state_t;
endpackage

//--- bst_ctl_if.sv
// Control bundle between the port core and its state machine.
`timescale 1ns/1ps
interface bst_ctl_if;
   import bst_pkg::*;
   logic       rise;
   logic       trst;
   logic       tms;
   bst_state_t state;
   modport fsm  (input rise, input trst, input tms, output state);
   modport core (output rise, output trst, output tms, input state);
endinterface

//--- bst_tap_fsm.sv
// Sixteen-state test port controller stepped by detected test-clock rises.
`timescale 1ns/1ps
module bst_tap_fsm
   import bst_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_in,
   bst_ctl_if.fsm    ctl
);
   bst_state_t state_q;
   bst_state_t state_d;
   logic [2:0] ones_q;
   logic [2:0] ones_d;

   // Next state follows the standard graph, only on a rise; reset pin overrides.
   always_comb begin
      state_d = state_q;
      ones_d = ones_q;
      if (ctl.rise) begin
         ones_d = ctl.tms ? ((ones_q == ONES_MAX) ? ones_q : ones_q + 3'h1) : 3'h0;
         case (state_q)
            ST_TLR:    state_d = ctl.tms ? ST_TLR : ST_RTI;
            ST_RTI:    state_d = ctl.tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_d = ctl.tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = ctl.tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  state_d = ctl.tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_d = ctl.tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  state_d = ctl.tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: state_d = ctl.tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_d = ctl.tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_d = ctl.tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: state_d = ctl.tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  state_d = ctl.tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_d = ctl.tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  state_d = ctl.tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: state_d = ctl.tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_d = ctl.tms ? ST_SEL_DR : ST_RTI;
            default:   state_d = ST_TLR;
         endcase
      end
      if (ctl.trst) begin
         state_d = ST_TLR;
         ones_d = 3'h0;
      end
   end

   // Registers the controller state and the count of mode-high rises.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= ST_TLR;
         ones_q <= 3'h0;
      end else begin
         state_q <= state_d;
         ones_q <= ones_d;
      end
   end

   assign ctl.state = state_q;

   a_still_no_rise: assert property (@(posedge clk_in) disable iff (rst_in)
      (!ctl.rise && !ctl.trst) |=> (state_q == $past(state_q)))
      else $error("State moved without a test-clock rise.");
   a_five_ones_reset: assert property (@(posedge clk_in) disable iff (rst_in)
      (ones_q >= ONES_RESET) |-> (state_q == ST_TLR))
      else $error("Five mode-high rises did not reach reset state.");
   a_exit_to_update: assert property (@(posedge clk_in) disable iff (rst_in)
      (ctl.rise && ctl.tms && !ctl.trst && (state_q == ST_EX1_DR || state_q == ST_EX2_DR)) |=> (state_q == ST_UPD_DR))
      else $error("Data exit with mode high did not reach update.");
   a_pin_reset_tlr: assert property (@(posedge clk_in) disable iff (rst_in)
      ctl.trst |=> (state_q == ST_TLR) [*2])
      else $error("Reset pin did not hold the reset state.");
   a_graph_shift_stay: assert property (@(posedge clk_in) disable iff (rst_in)
      (ctl.rise && !ctl.tms && !ctl.trst && state_q == ST_SH_DR) |=> (state_q == ST_SH_DR))
      else $error("Shift-data left with mode low.");
endmodule

//--- bst_tester.sv
// Test controller model that drives the scan pins and samples the serial output.
`timescale 1ns/1ps
module bst_tester (
   input  wire logic clk_in,
   input  wire logic tdo_in,
   input  wire logic tdo_oe_n_in,
   output logic      tck_out,
   output logic      tms_out,
   output logic      tdi_out,
   output logic      trst_n_out
);
   logic tdo_q;
   logic oe_n_q;

   // Pins start idle with the test clock parked low.
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
      trst_n_out = 1'b1;
      tdo_q = 1'b0;
      oe_n_q = 1'b1;
   end

   // One test-clock period: fall with new mode and data, rise four clocks later.
   task automatic step(input logic tms, input logic tdi);
      @(posedge clk_in);
      #1 tck_out = 1'b0;
      tms_out = tms;
      tdi_out = tdi;
      repeat (4) @(posedge clk_in);
      #1 tdo_q = tdo_in;
      oe_n_q = tdo_oe_n_in;
      tck_out = 1'b1;
      repeat (3) @(posedge clk_in); // High half of the 320 ns test-clock period.
   endtask

   // Moves mode select while the test clock stands still.
   task automatic hold(input logic tms, input int n);
      @(posedge clk_in);
      #1 tms_out = tms;
      repeat (n) @(posedge clk_in);
   endtask

   // Pulls the test reset pin low for n clocks.
   task automatic pulse_reset(input int n);
      @(posedge clk_in);
      #1 trst_n_out = 1'b0;
      repeat (n) @(posedge clk_in);
      #1 trst_n_out = 1'b1;
   endtask
endmodule

//--- testbench.sv
// Self-checking bench for the boundary-scan access port.
`timescale 1ns/1ps
module testbench;
   import bst_pkg::*;
   localparam logic [3:0]  VER = 4'h6;    // Arbitrary value.
   localparam logic [15:0] PART = 16'hA5C3; // Arbitrary value.
   localparam logic [10:0] MFR = 11'h2B1;  // Arbitrary value.
   localparam logic [31:0] ID_EXP = {VER, PART, MFR, ID_MARK};
   localparam int          LIMIT = 30000;
   logic       sys_clk = 1'b0;
   logic       reset = 1'b1;
   logic [7:0] cap = 8'h00;
   logic       tck, tms, tdi, trst_n, tdo, oe_n, extest, highz, tap_rst, tdo_line;
   logic [7:0] upd;
   logic       mid_ext;
   logic [7:0] mid_upd;
   int         num_errors = 0;
   int         n_checks = 0;
   int         cycles = 0;

   // Released serial line floats to its pull-up level.
   assign tdo_line = oe_n ? 1'b1 : tdo;

   bst_tap_core #(.BSR_LEN(8), .ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR)) bst_tap_core_inst (
      .SYS_CLK_IN(sys_clk), .RESET_IN(reset), .TEST_CLOCK_INPUT_IN(tck), .TEST_MODE_IN(tms),
      .TEST_DATA_IN(tdi), .TEST_RESET_N_IN(trst_n), .BSC_CAPTURE_IN(cap), .TEST_DATA_OUT(tdo),
      .TEST_DATA_OE_N_OUT(oe_n), .BSC_UPDATE_OUT(upd), .EXTEST_OUT(extest), .HIGHZ_OUT(highz),
      .TAP_RESET_OUT(tap_rst));

   bst_tester bst_tester_inst (
      .clk_in(sys_clk), .tdo_in(tdo_line), .tdo_oe_n_in(oe_n), .tck_out(tck), .tms_out(tms),
      .tdi_out(tdi), .trst_n_out(trst_n));

   // System clock and the cycle ceiling that cuts a hang short.
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         num_errors++;
         results();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      if (num_errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Full scan from idle back to idle, with an optional pause before bit pz.
   task automatic scan(input logic ir, input int n, input logic [31:0] din, input int pz,
                       output logic [31:0] dout);
      dout = '0;
      bst_tester_inst.step(1'b1, 1'b0);
      if (ir) bst_tester_inst.step(1'b1, 1'b0);
      bst_tester_inst.step(1'b0, 1'b0);
      bst_tester_inst.step(1'b0, 1'b0);
      for (int i = 0; i < n; i++) begin
         if (i == pz && pz > 0) begin
            bst_tester_inst.step(1'b0, 1'b0);
            bst_tester_inst.step(1'b0, 1'b0);
            mid_ext = extest;
            mid_upd = upd;
            check(32'(bst_tester_inst.oe_n_q), 32'h1);
            bst_tester_inst.step(1'b1, 1'b0);
            bst_tester_inst.step(1'b0, 1'b0);
         end
         bst_tester_inst.step(i == n - 1 || i == pz - 1, din[i]);
         dout[i] = bst_tester_inst.tdo_q;
         check(32'(bst_tester_inst.oe_n_q), 32'h0);
      end
      bst_tester_inst.step(1'b1, 1'b0);
      check(32'(bst_tester_inst.oe_n_q), 32'h1);
      bst_tester_inst.step(1'b0, 1'b0);
      repeat (6) @(posedge sys_clk);
   endtask

   task automatic load_ir(input logic [3:0] code, input int pz);
      logic [31:0] d;
      scan(1'b1, 4, 32'(code), pz, d);
      check(d, 32'(IR_CAPTURE));
   endtask

   // Identity is the default instruction after reset.
   task automatic t_id();
      logic [31:0] d;
      bst_tester_inst.step(1'b0, 1'b0);
      scan(1'b0, 32, 32'h0, 0, d);
      check(d, ID_EXP);
   endtask

   // Instruction pause keeps the old instruction; data pause keeps the latches.
   task automatic t_extest();
      logic [31:0] d;
      load_ir(OP_EXTEST, 2);
      check(32'(mid_ext), 32'h0);
      check(32'(extest), 32'h1);
      #1 cap = 8'hA5;
      scan(1'b0, 8, 32'h3C, 4, d);
      check(d, 32'hA5);
      check(32'(mid_upd), 32'h0);
      check(32'(upd), 32'h3C);
   endtask

   // Each defined instruction code and code 7, with its selected data path and mode outputs.
   task automatic t_codes();
      logic [3:0]  codes [6] = '{OP_SAMPLE, OP_HIGHZ, OP_IDENT, OP_BYPASS, 4'h7, OP_EXTEST};
      logic [7:0]  exp [6] = '{8'h5A, 8'hFE, ID_EXP[7:0], 8'hFE, 8'hFE, 8'h5A};
      logic [31:0] d;
      #1 cap = 8'h5A;
      for (int k = 0; k < 6; k++) begin
         load_ir(codes[k], 0);
         check(32'({highz, extest}), 32'({codes[k] == OP_HIGHZ, codes[k] == OP_EXTEST}));
         scan(1'b0, 8, 32'hFF, 0, d);
         check(d, 32'(exp[k]));
      end
   endtask

   // Four mode-high rises from shift do not reset; the fifth does.
   task automatic t_tms_reset();
      bst_tester_inst.step(1'b1, 1'b0);
      bst_tester_inst.step(1'b0, 1'b0);
      bst_tester_inst.step(1'b0, 1'b0);
      repeat (4) bst_tester_inst.step(1'b1, 1'b0);
      repeat (6) @(posedge sys_clk);
      check(32'(tap_rst), 32'h0);
      bst_tester_inst.step(1'b1, 1'b0);
      repeat (6) @(posedge sys_clk);
      check(32'({tap_rst, extest}), 32'h2);
   endtask

   // Mode select alone, without test-clock rises, moves nothing.
   task automatic t_no_clock();
      bst_tester_inst.step(1'b0, 1'b0);
      bst_tester_inst.hold(1'b1, 40);
      check(32'(tap_rst), 32'h0);
   endtask

   // Reset pin returns the controller to reset with the identity instruction.
   task automatic t_trst();
      load_ir(OP_EXTEST, 0);
      check(32'(extest), 32'h1);
      bst_tester_inst.pulse_reset(6);
      repeat (6) @(posedge sys_clk);
      check(32'({tap_rst, extest, highz}), 32'h4);
   endtask

   // Main sequence: the port is reset before any scan.
   initial begin
      repeat (10) @(posedge sys_clk);
      #1 reset = 1'b0;
      repeat (2) @(posedge sys_clk);
      check(32'({tap_rst, extest, highz, oe_n, upd}), 32'h9_00);
      bst_tester_inst.pulse_reset(6);
      repeat (6) @(posedge sys_clk);
      t_id();
      t_extest();
      t_codes();
      t_tms_reset();
      t_no_clock();
      t_trst();
      results();
   end
endmodule
